//--- rtl/fcp_defines.vh
// Register map, field positions, reset values and command codes of the
// flash command and protection block.
// Assumes inclusion by bare name from the design files.
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

// ----------------------------------------------------------------------
// Parameter register word index and register byte addresses (word aligned)
// ----------------------------------------------------------------------
`define FCP_IDX_PARAM     4'hA
`define FCP_ADDR_PARAM    8'h28
`define FCP_ADDR_INDEX    8'h00
`define FCP_ADDR_STATUS   8'h04
`define FCP_ADDR_PPROT    8'h08
`define FCP_ADDR_DPROT    8'h0C
`define FCP_ADDR_CTRL     8'h10

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define FCP_ST_COMPLETE   7
`define FCP_ST_ACCESS_ERROR_FLAG     5
`define FCP_ST_PVIOL      4

// ----------------------------------------------------------------------
// Program and data flash protection fields, range bounds and reset image address
// ----------------------------------------------------------------------
`define FCP_PP_OPEN       7
`define FCP_PP_HDIS       5
`define FCP_PP_LDIS       2
`define FCP_DP_OPEN       7
`define FCP_DP_DIS        3
`define FCP_PROT_IMG_ADDR 23'h7FFF0C
`define FCP_HIGH_TOP      23'h7FFFFF
`define FCP_LOW_BASE      23'h7F8000
`define FCP_LOW_1K_TOP    23'h7F83FF
`define FCP_HIGH_2K_BASE  23'h7FF800

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define FCP_CMD_ERASE_ALL 8'h08
`define FCP_CMD_UNSECURE  8'h0B
`define FCP_CMD_USR_MARG  8'h0D
`define FCP_CMD_FLD_MARG  8'h0E
`define FCP_CMD_FULL_PART 8'h0F
`define FCP_CMD_ERS_VFY   8'h10
`define FCP_CMD_PROG      8'h11
`define FCP_CMD_ERS_SECT  8'h12
`define FCP_CMD_EE_ON     8'h13
`define FCP_CMD_EE_OFF    8'h14
`define FCP_CMD_EE_QUERY  8'h15
`define FCP_CMD_PART      8'h20

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define FCP_PROT_RST      8'hFF
`define FCP_OP_CYCLES     16'h0010

`endif

//--- rtl/fcp_prot_check.v
// Program flash protection range decoder.
// Assumes the protection byte and address are stable in the checked cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.vh"

module fcp_prot_check (
  // Protection setting
  input  wire [7:0]  pflash_protect_reg_i,
  // Address to check
  input  wire [22:0] addr_i,
  // Result
  output wire        protected_o
);

  // ----------------------------------------------------------------------
  // Range decode
  // ----------------------------------------------------------------------
  wire       open_w = pflash_protect_reg_i[`FCP_PP_OPEN];
  wire       hdis_w = pflash_protect_reg_i[`FCP_PP_HDIS];
  wire       ldis_w = pflash_protect_reg_i[`FCP_PP_LDIS];
  wire [1:0] hs_w   = pflash_protect_reg_i[4:3];
  wire [1:0] ls_w   = pflash_protect_reg_i[1:0];
  wire [22:0] hbase_w = `FCP_HIGH_2K_BASE - ((23'h000800 << hs_w) - 23'h000800);
  wire [22:0] ltop_w  = `FCP_LOW_BASE + ((23'h000400 << ls_w) - 23'h000001);
  wire in_high_w = (addr_i >= hbase_w) && (addr_i <= `FCP_HIGH_TOP);
  wire in_low_w  = (addr_i >= `FCP_LOW_BASE) && (addr_i <= ltop_w);
  wire in_any_w  = (!hdis_w && in_high_w) || (!ldis_w && in_low_w);

  // Open: listed ranges protected; closed: listed ranges are the only hole
  assign protected_o = open_w ? in_any_w : !in_any_w;

endmodule
`default_nettype wire

//--- rtl/fcp_flash_cmd.v
// Flash command sequencer with indexed parameter array and protection.
// Assumes a classic Wishbone master and a flash array modelled by a
// fixed operation time; one clock, synchronous active-high reset.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.vh"

module fcp_flash_cmd #(
  parameter [15:0] OP_CYCLES = `FCP_OP_CYCLES,
  parameter [15:0] EE_SIZE   = 16'h0010
) (
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Mode and reset image of protection
  input  wire        special_mode_i,
  input  wire [7:0]  prot_image_i,
  output wire [22:0] prot_image_addr_o,
  // Flash array side
  input  wire        flash_erased_i,
  output reg         flash_prog_o,
  output reg         flash_erase_o,
  output reg  [22:0] flash_addr_o,
  output reg  [15:0] flash_wdata_o,
  input  wire [15:0] flash_rdata_i,
  output wire [15:0] flash_read_data_o,
  // Events
  output wire        cmd_complete_flag_o,
  output wire        irq_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0, S_CHECK = 3'h1, S_ERASE = 3'h2, S_VERIFY = 3'h3,
                   S_PROG = 3'h4, S_DONE = 3'h5;
  localparam [7:0] CTRL_IE_DONE = 8'h01, CTRL_IE_ERR = 8'h02;

  reg [15:0] command_param_array [0:5];
  reg [2:0]  param_index_reg;
  reg        cmd_complete_flag_reg;
  reg        access_error_flag_reg;
  reg        protect_violation_flag_reg;
  reg        verify_fail_reg;
  reg [7:0]  pflash_protect_reg;
  reg [7:0]  dflash_protect_reg;
  reg [7:0]  ctrl_reg;
  reg        emulated_eeprom_reg;
  reg        margin_user_reg;
  reg        partitioned_reg;
  reg        prot_loaded_reg;
  reg [2:0]  state_reg;
  reg [15:0] timer_reg;
  reg [2:0]  word_cnt_reg;
  reg        ack_next;
  integer    i;

  wire [7:0]  command_code = command_param_array[0][15:8];
  wire [22:0] cmd_addr     = {command_param_array[0][6:0], command_param_array[1]};
  wire        addr_prot;
  wire        wb_req  = cyc_i && stb_i && !ack_o;
  wire        wb_wr   = cyc_i && stb_i && we_i && ack_o && ce_i; // Lands on the ack edge
  wire        busy    = !cmd_complete_flag_reg;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function valid_cmd;
    input [7:0] code;
    input       spec;
    begin
      case (code)
        `FCP_CMD_ERASE_ALL, `FCP_CMD_UNSECURE, `FCP_CMD_USR_MARG, `FCP_CMD_FULL_PART,
        `FCP_CMD_ERS_VFY, `FCP_CMD_PROG, `FCP_CMD_ERS_SECT, `FCP_CMD_EE_ON,
        `FCP_CMD_EE_OFF, `FCP_CMD_EE_QUERY, `FCP_CMD_PART: valid_cmd = 1'b1;
        `FCP_CMD_FLD_MARG: valid_cmd = spec;
        default: valid_cmd = 1'b0;
      endcase
    end
  endfunction

  function is_alter;
    input [7:0] code;
    begin
      is_alter = (code == `FCP_CMD_PROG) || (code == `FCP_CMD_ERS_SECT);
    end
  endfunction

  // Full erase allowed only with every protection disabled
  wire erase_all_ok = pflash_protect_reg[`FCP_PP_OPEN] && pflash_protect_reg[`FCP_PP_HDIS] &&
                      pflash_protect_reg[`FCP_PP_LDIS] && dflash_protect_reg[`FCP_DP_OPEN] &&
                      dflash_protect_reg[`FCP_DP_DIS];

  // ----------------------------------------------------------------------
  // Protection range check
  // ----------------------------------------------------------------------
  fcp_prot_check u_prot (
    .pflash_protect_reg_i (pflash_protect_reg),
    .addr_i               (cmd_addr),
    .protected_o          (addr_prot)
  );

  assign prot_image_addr_o   = `FCP_PROT_IMG_ADDR;
  assign cmd_complete_flag_o = cmd_complete_flag_reg;
  assign flash_read_data_o   = busy ? 16'h0000 : flash_rdata_i;
  assign irq_o = (ctrl_reg[0] && cmd_complete_flag_reg) ||
                 (ctrl_reg[1] && (access_error_flag_reg || protect_violation_flag_reg));

  // ----------------------------------------------------------------------
  // Bus read mux
  // ----------------------------------------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (adr_i)
      `FCP_ADDR_PARAM: begin
        if (param_index_reg < 3'h6 && !busy) begin
          rd_mux = {16'h0000, command_param_array[param_index_reg]};
        end
      end
      `FCP_ADDR_INDEX:  rd_mux = {29'h00000000, param_index_reg};
      `FCP_ADDR_STATUS: rd_mux = {24'h000000, cmd_complete_flag_reg, 1'b0,
                                  access_error_flag_reg, protect_violation_flag_reg,
                                  3'h0, verify_fail_reg};
      `FCP_ADDR_PPROT:  rd_mux = {24'h000000, pflash_protect_reg};
      `FCP_ADDR_DPROT:  rd_mux = {24'h000000, dflash_protect_reg};
      `FCP_ADDR_CTRL:   rd_mux = {21'h000000, partitioned_reg, margin_user_reg,
                                  emulated_eeprom_reg, ctrl_reg};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus handshake: ack one cycle after request, read data registered,
  // writes take effect at the edge that samples ack high
  // ----------------------------------------------------------------------
  always @* begin
    ack_next = wb_req;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= ack_next;
      if (wb_req) begin
        dat_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers and command sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 6; i = i + 1) begin
        command_param_array[i] <= 16'h0000;
      end
      param_index_reg            <= 3'h0;
      cmd_complete_flag_reg      <= 1'b1;
      access_error_flag_reg      <= 1'b0;
      protect_violation_flag_reg <= 1'b0;
      verify_fail_reg            <= 1'b0;
      pflash_protect_reg         <= `FCP_PROT_RST;
      dflash_protect_reg         <= `FCP_PROT_RST;
      ctrl_reg                   <= 8'h00;
      emulated_eeprom_reg        <= 1'b0;
      margin_user_reg            <= 1'b0;
      partitioned_reg            <= 1'b0;
      prot_loaded_reg            <= 1'b0;
      state_reg                  <= S_IDLE;
      timer_reg                  <= 16'h0000;
      word_cnt_reg               <= 3'h0;
      flash_prog_o               <= 1'b0;
      flash_erase_o              <= 1'b0;
      flash_addr_o               <= 23'h000000;
      flash_wdata_o              <= 16'h0000;
    end else if (ce_i) begin
      flash_prog_o  <= 1'b0;
      flash_erase_o <= 1'b0;
      // Catch protection image after reset release
      if (!prot_loaded_reg) begin
        pflash_protect_reg <= prot_image_i;
        prot_loaded_reg    <= 1'b1;
      end
      // Software writes
      if (wb_wr && sel_i[0]) begin
        case (adr_i)
          `FCP_ADDR_PARAM: begin
            if (!busy && param_index_reg < 3'h6) begin
              command_param_array[param_index_reg] <= dat_i[15:0];
            end
          end
          `FCP_ADDR_INDEX: begin
            if (!busy) begin
              param_index_reg <= dat_i[2:0];
            end
          end
          `FCP_ADDR_PPROT: pflash_protect_reg <= dat_i[7:0];
          `FCP_ADDR_DPROT: dflash_protect_reg <= dat_i[7:0];
          `FCP_ADDR_CTRL:  ctrl_reg <= dat_i[7:0] & (CTRL_IE_DONE | CTRL_IE_ERR);
          `FCP_ADDR_STATUS: begin
            if (dat_i[`FCP_ST_ACCESS_ERROR_FLAG]) access_error_flag_reg <= 1'b0;
            if (dat_i[`FCP_ST_PVIOL])  protect_violation_flag_reg <= 1'b0;
            // Launch only when idle and error flags already clear
            if (dat_i[`FCP_ST_COMPLETE] && !busy && !access_error_flag_reg &&
                !protect_violation_flag_reg) begin
              cmd_complete_flag_reg <= 1'b0;
              verify_fail_reg       <= 1'b0;
              state_reg             <= S_CHECK;
            end
          end
          default: ;
        endcase
      end
      // Command execution
      case (state_reg)
        S_IDLE: ;
        S_CHECK: begin
          timer_reg    <= OP_CYCLES;
          flash_addr_o <= cmd_addr;
          word_cnt_reg <= 3'h0;
          if (!valid_cmd(command_code, special_mode_i)) begin
            access_error_flag_reg <= 1'b1;
            state_reg             <= S_DONE;
          end else if (command_code == `FCP_CMD_ERASE_ALL && !erase_all_ok) begin
            protect_violation_flag_reg <= 1'b1;
            state_reg                  <= S_DONE;
          end else if (is_alter(command_code) && addr_prot) begin
            protect_violation_flag_reg <= 1'b1;
            state_reg                  <= S_DONE;
          end else begin
            case (command_code)
              `FCP_CMD_ERASE_ALL, `FCP_CMD_UNSECURE, `FCP_CMD_FULL_PART,
              `FCP_CMD_ERS_SECT: state_reg <= S_ERASE;
              `FCP_CMD_ERS_VFY:  state_reg <= S_VERIFY;
              `FCP_CMD_PROG:     state_reg <= S_PROG;
              `FCP_CMD_USR_MARG, `FCP_CMD_FLD_MARG: begin
                margin_user_reg <= (command_code == `FCP_CMD_USR_MARG);
                state_reg       <= S_DONE;
              end
              `FCP_CMD_PART: begin
                partitioned_reg <= 1'b1;
                state_reg       <= S_DONE;
              end
              `FCP_CMD_EE_ON: begin
                emulated_eeprom_reg <= 1'b1;
                state_reg           <= S_DONE;
              end
              `FCP_CMD_EE_OFF: begin
                emulated_eeprom_reg <= 1'b0;
                state_reg           <= S_DONE;
              end
              `FCP_CMD_EE_QUERY: begin
                command_param_array[1] <= EE_SIZE;
                command_param_array[2] <= {14'h0000, partitioned_reg, emulated_eeprom_reg};
                state_reg              <= S_DONE;
              end
              default: state_reg <= S_DONE;
            endcase
          end
        end
        S_ERASE: begin
          if (timer_reg == OP_CYCLES) flash_erase_o <= 1'b1;
          if (timer_reg == 16'h0000) begin
            if (command_code == `FCP_CMD_UNSECURE) begin
              timer_reg <= OP_CYCLES;
              state_reg <= S_VERIFY;
            end else begin
              if (command_code == `FCP_CMD_FULL_PART) partitioned_reg <= 1'b1;
              state_reg <= S_DONE;
            end
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        S_VERIFY: begin
          if (!flash_erased_i) verify_fail_reg <= 1'b1;
          if (timer_reg == 16'h0000) state_reg <= S_DONE;
          else timer_reg <= timer_reg - 16'h0001;
        end
        S_PROG: begin
          if (timer_reg == OP_CYCLES) begin
            flash_prog_o  <= 1'b1;
            flash_wdata_o <= command_param_array[3'h2 + word_cnt_reg];
          end
          if (timer_reg == 16'h0000) begin
            // Up to four words from index 2 onward
            if (word_cnt_reg == 3'h3 || param_index_reg <= (3'h2 + word_cnt_reg)) begin
              state_reg <= S_DONE;
            end else begin
              word_cnt_reg <= word_cnt_reg + 3'h1;
              flash_addr_o <= flash_addr_o + 23'h000002;
              timer_reg    <= OP_CYCLES;
            end
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        S_DONE: begin
          cmd_complete_flag_reg <= 1'b1;
          state_reg             <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- testbench/fcp_checker.sv
// Port checker for the flash command block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fcp_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Flash side and events
  input wire logic [22:0] prot_image_addr_o,
  input wire logic        flash_prog_o,
  input wire logic        flash_erase_o,
  input wire logic [15:0] flash_read_data_o,
  input wire logic        cmd_complete_flag_o
);
  // ----------------------------------------------------------------
  // Relations between ports
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_req_answered: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_image_addr_fixed: assert property (prot_image_addr_o == 23'h7FFF0C)
    else $error("image address wrong");
  a_busy_read_zero: assert property (!cmd_complete_flag_o |-> flash_read_data_o == 16'h0000)
    else $error("busy read shows data");
  a_launch_by_write: assert property ($fell(cmd_complete_flag_o) |-> $past(ack_o && we_i
    && adr_i == 8'h04 && dat_i[7])) else $error("launch without status write");
  a_lock_holds: assert property ($fell(cmd_complete_flag_o) |=> !cmd_complete_flag_o)
    else $error("complete flag back too soon");
  a_prog_when_busy: assert property (flash_prog_o |-> !cmd_complete_flag_o)
    else $error("program pulse while idle");
  a_erase_when_busy: assert property (flash_erase_o |-> !cmd_complete_flag_o)
    else $error("erase pulse while idle");
  c_launch: cover property ($fell(cmd_complete_flag_o));
  c_prog: cover property (flash_prog_o);
  c_erase: cover property (flash_erase_o);
endmodule
bind fcp_flash_cmd fcp_checker i_fcp_checker (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
  .prot_image_addr_o(prot_image_addr_o), .flash_prog_o(flash_prog_o),
  .flash_erase_o(flash_erase_o), .flash_read_data_o(flash_read_data_o),
  .cmd_complete_flag_o(cmd_complete_flag_o));
`default_nettype wire

//--- testbench/test_fcp_flash_cmd.sv
// Self-checking bench for the flash command block with a register model.
// Assumes the design's register map and classic Wishbone timing.
`timescale 1ns/1ps
`default_nettype none
`include "fcp_defines.vh"
module test_fcp_flash_cmd;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, special_mode_i, flash_erased_i;
  logic [7:0]  adr_i, prot_image_i, p;
  logic [31:0] dat_i, rd;
  logic [15:0] flash_rdata_i, last_data;
  logic [22:0] last_addr, a;
  wire  [31:0] dat_o;
  wire  [22:0] prot_image_addr_o, flash_addr_o;
  wire  [15:0] flash_wdata_o, flash_read_data_o;
  wire         ack_o, flash_prog_o, flash_erase_o, cmd_complete_flag_o, irq_o;
  integer      errors, checked, seed, k;
  integer      progs = 0;
  logic [15:0] prm [0:7];
  logic [7:0]  codes [0:11];

  fcp_flash_cmd i_fcp_flash_cmd (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .special_mode_i(special_mode_i), .prot_image_i(prot_image_i),
    .prot_image_addr_o(prot_image_addr_o), .flash_erased_i(flash_erased_i),
    .flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o),
    .flash_wdata_o(flash_wdata_o), .flash_rdata_i(flash_rdata_i),
    .flash_read_data_o(flash_read_data_o), .cmd_complete_flag_o(cmd_complete_flag_o),
    .irq_o(irq_o));

  // Clock at 40 MHz
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Random array data; program pulses are counted and captured
  always @(posedge clk_i) begin
    flash_rdata_i <= 16'($random(seed));
    if (flash_prog_o === 1'b1) begin
      progs <= progs + 1;
      last_addr <= flash_addr_o;
      last_data <= flash_wdata_o;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; waits for ack under a bound
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    integer t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= d;
    for (t = 0; t < 200 && ack_o !== 1'b1; t++) @(posedge clk_i);
    if (t == 200) begin
      errors = errors + 1;
      give_verdict();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    cmp(rd, e);
  endtask

  // Writes a parameter word and records it in the model
  task automatic setp(input logic [2:0] i, input logic [15:0] v);
    bus(1'b1, `FCP_ADDR_INDEX, {29'h0, i});
    bus(1'b1, `FCP_ADDR_PARAM, {16'h0, v});
    prm[i] = (i > 3'h5) ? 16'h0000 : v;
  endtask

  // Loads and launches a command, then checks flags and results
  task automatic run(input logic [7:0] c, input logic [22:0] ca, input logic ep, input logic ea);
    integer t, n;
    setp(3'h0, {c, 1'b0, ca[22:16]});
    setp(3'h1, ca[15:0]);
    setp(3'h2, (c == 8'h10) ? 16'h0003 : 16'($random(seed)));
    setp(3'h3, 16'($random(seed)));
    n = progs;
    bus(1'b1, `FCP_ADDR_STATUS, 32'h80);
    @(posedge clk_i);
    // Lock is only observable on commands that outlast two bus cycles
    if (!ea && !ep && c inside {8'h08, 8'h0B, 8'h0F, 8'h10, 8'h11, 8'h12}) begin
      bus(1'b1, `FCP_ADDR_PARAM, 32'h5A5A);
      chk(`FCP_ADDR_PARAM, 32'h0);
    end
    // Clock enable low freezes the running erase
    if (c == 8'h12) begin
      ce_i <= 1'b0;
      repeat (40) @(posedge clk_i);
      cmp({31'h0, cmd_complete_flag_o}, 32'h0);
      ce_i <= 1'b1;
    end
    for (t = 0; t < 3000 && cmd_complete_flag_o !== 1'b1; t++) @(posedge clk_i);
    if (t == 3000) begin
      errors = errors + 1;
      give_verdict();
    end
    bus(1'b0, `FCP_ADDR_STATUS, 32'h0);
    cmp(rd & 32'hB0, {24'h0, 2'b10, ea, ep, 4'h0});
    if (!ea) chk(`FCP_ADDR_PARAM, {16'h0, prm[3]});
    // Launch with index 3 programs the words at index 2 and 3
    if (c == 8'h11) cmp(progs - n, (ep || ea) ? 0 : 2);
    if (c == 8'h11 && !ep) cmp({9'h0, last_addr}, {9'h0, ca + 23'h000002});
    if (c == 8'h11 && !ep) cmp({16'h0, last_data}, {16'h0, prm[3]});
    bus(1'b1, `FCP_ADDR_STATUS, 32'h30);
  endtask

  // Protection of an address from the protection byte
  function automatic logic prot(input logic [7:0] pb, input logic [22:0] ad);
    logic h, l;
    h = !pb[5] && int'(ad) >= 32'h800000 - (2048 << pb[4:3]);
    l = !pb[2] && int'(ad) < 32'h7F8000 + (1024 << pb[1:0]) && ad >= 23'h7F8000;
    return pb[7] ? (h || l) : !(h || l);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 37129;
    errors = 0;
    checked = 0;
    {cyc_i, stb_i, we_i, special_mode_i, adr_i, dat_i} = '0;
    ce_i = 1'b1;
    flash_erased_i = 1'b1;
    prot_image_i = 8'($random(seed));
    rst_i = 1'b1;
    codes = '{8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
              8'h15, 8'h20};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, `FCP_ADDR_PPROT, 32'h0);
    cmp(rd & 32'hBF, {24'h0, prot_image_i & 8'hBF});
    chk(`FCP_ADDR_DPROT, 32'hFF);
    $display("reset test done");
    for (k = 0; k < 8; k++) setp(3'(k), 16'($random(seed)));
    for (k = 0; k < 8; k++) begin
      bus(1'b1, `FCP_ADDR_INDEX, k);
      chk(`FCP_ADDR_PARAM, {16'h0, prm[k]});
    end
    bus(1'b1, 8'hFC, 32'h1234);
    chk(8'hFC, 32'h0);
    $display("parameter test done");
    bus(1'b1, `FCP_ADDR_PPROT, 32'hFF);
    special_mode_i <= 1'b1;
    for (k = 0; k < 12; k++) run(codes[k], 23'h100000, 1'b0, 1'b0);
    run(`FCP_CMD_EE_QUERY, 23'h0, 1'b0, 1'b0);
    bus(1'b1, `FCP_ADDR_INDEX, 32'h1);
    chk(`FCP_ADDR_PARAM, 32'h10);
    special_mode_i <= 1'b0;
    run(`FCP_CMD_FLD_MARG, 23'h0, 1'b0, 1'b1);
    run(8'h3F, 23'h0, 1'b0, 1'b1);
    bus(1'b1, `FCP_ADDR_DPROT, 32'hF7);
    run(`FCP_CMD_ERASE_ALL, 23'h0, 1'b1, 1'b0);
    bus(1'b1, `FCP_ADDR_DPROT, 32'hFF);
    $display("command test done");
    for (k = 0; k < 24; k++) begin
      p = 8'($random(seed));
      a = 23'h7F8000 + (23'($random(seed)) & 23'h007FFE);
      bus(1'b1, `FCP_ADDR_PPROT, {24'h0, p});
      run(`FCP_CMD_PROG, a, prot(p, a), 1'b0);
    end
    $display("protection test done");
    give_verdict();
  end
endmodule
`default_nettype wire
